// ---- design/art_timer.sv ----
// auto-reload timer: one 16-bit counter or two 8-bit counters, reached
// through the core's special function register port
// assumes sfr_rd/sfr_wr are one-cycle strobes from the core on clock, and
// timer_irq_enable and the two byte clock selects come from core registers
`timescale 1ns/1ps
`include "art_cfg.svh"

module art_timer import art_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic timer_irq_enable,
  input wire logic high_byte_clock_select,
  input wire logic low_byte_clock_select,
  input wire logic ext_osc,
  output logic [7:0] sfr_rdata_r,
  output logic irq_req_r
);

  art_sfr_req_t req;
  art_ticks_t ticks;

  // control fields
  logic high_overflow_flag_r, high_overflow_flag_nxt;
  logic low_overflow_flag_r, low_overflow_flag_nxt;
  logic low_overflow_irq_enable_r, low_overflow_irq_enable_nxt;
  logic lowfreq_capture_enable_r, lowfreq_capture_enable_nxt;
  logic split_mode_select_r, split_mode_select_nxt;
  logic run_control_r, run_control_nxt;
  logic external_clock_select_r, external_clock_select_nxt;

  logic [7:0] reload_low_byte_r, reload_low_byte_nxt;
  logic [7:0] reload_high_byte_r, reload_high_byte_nxt;
  logic [7:0] low_counter_r, low_counter_nxt;
  logic [7:0] high_counter_r, high_counter_nxt;
  logic [7:0] sfr_rdata_nxt;
  logic irq_req_nxt;

  logic tick_lo, tick_hi, set_h, set_l, capture;
  logic wr_ctrl, wr_rll, wr_rlh, wr_cl, wr_ch;

  assign req.wr = sfr_wr;
  assign req.rd = sfr_rd;
  assign req.addr = sfr_addr;
  assign req.wdata = sfr_wdata;

  art_clk_src #(
    .SYS_DIV(`ART_SYS_DIV),
    .EXT_DIV(`ART_EXT_DIV)
  ) u_clk_src (
    .clock(clock),
    .reset(reset),
    .ext_osc(ext_osc),
    .ticks(ticks)
  );

  function automatic art_src_t src_of(input logic byte_sel,
                                      input logic xclk);
    if (byte_sel) begin
      src_of = ART_SRC_SYS;
    end else if (xclk) begin
      src_of = ART_SRC_EXT8;
    end else begin
      src_of = ART_SRC_DIV12;
    end
  endfunction : src_of

  function automatic logic tick_of(input art_src_t src,
                                   input art_ticks_t tk);
    case (src)
      ART_SRC_SYS: tick_of = 1'b1;
      ART_SRC_EXT8: tick_of = tk.tick_ext_div;
      ART_SRC_DIV12: tick_of = tk.tick_sys_div;
      default: tick_of = 1'b0;
    endcase
  endfunction : tick_of

  // a write strobe aimed at one register
  function automatic logic wr_hit(input art_sfr_req_t rq,
                                  input logic [7:0] addr);
    wr_hit = rq.wr && (rq.addr == addr);
  endfunction : wr_hit

  // a byte at all ones, whose next tick overflows it (wrap to zero or reload)
  function automatic logic at_top(input logic [7:0] value);
    at_top = (value == `ART_BYTE_MAX);
  endfunction : at_top

  // control byte as software sees it; the unused bit reads zero
  function automatic logic [7:0] ctrl_image(input logic hi_flag,
                                            input logic lo_flag,
                                            input logic lo_en,
                                            input logic cap_en,
                                            input logic split,
                                            input logic run,
                                            input logic xclk);
    ctrl_image = `ART_CTRL_RESET;
    ctrl_image[`ART_BIT_TFH] = hi_flag;
    ctrl_image[`ART_BIT_TFL] = lo_flag;
    ctrl_image[`ART_BIT_LEN] = lo_en;
    ctrl_image[`ART_BIT_CEN] = cap_en;
    ctrl_image[`ART_BIT_SPLIT] = split;
    ctrl_image[`ART_BIT_RUN] = run;
    ctrl_image[`ART_BIT_XCLK] = xclk;
  endfunction : ctrl_image

  // write decode and capture event, shared by the counting, reload and control groups below
  always_comb begin
    wr_ctrl = wr_hit(req, `ART_ADDR_CTRL);
    wr_rll = wr_hit(req, `ART_ADDR_RLD_LO);
    wr_rlh = wr_hit(req, `ART_ADDR_RLD_HI);
    wr_cl = wr_hit(req, `ART_ADDR_CNT_LO);
    wr_ch = wr_hit(req, `ART_ADDR_CNT_HI);
    // capture follows every synchronised rising oscillator edge, not the /8 tick
    capture = lowfreq_capture_enable_r && timer_irq_enable &&
              ticks.ext_edge;
  end

  // counting and flag setting
  always_comb begin
    tick_lo = tick_of(src_of(low_byte_clock_select,
                             external_clock_select_r), ticks);
    tick_hi = tick_of(src_of(high_byte_clock_select,
                             external_clock_select_r), ticks);
    set_h = 1'b0;
    set_l = 1'b0;
    low_counter_nxt = low_counter_r;
    high_counter_nxt = high_counter_r;
    if (!split_mode_select_r) begin
      if (tick_lo && run_control_r) begin
        low_counter_nxt = low_counter_r + 8'h01;
        // the low flag marks each carry from the low byte into the high byte
        if (at_top(low_counter_r)) begin
          set_l = 1'b1;
          high_counter_nxt = high_counter_r + 8'h01;
          if (at_top(high_counter_r)) begin
            low_counter_nxt = reload_low_byte_r;
            high_counter_nxt = reload_high_byte_r;
            set_h = 1'b1;
          end
        end
      end
    end else begin
      if (tick_lo) begin
        low_counter_nxt = low_counter_r + 8'h01;
        if (at_top(low_counter_r)) begin
          low_counter_nxt = reload_low_byte_r;
          set_l = 1'b1;
        end
      end
      if (tick_hi && run_control_r) begin
        high_counter_nxt = high_counter_r + 8'h01;
        if (at_top(high_counter_r)) begin
          high_counter_nxt = reload_high_byte_r;
          set_h = 1'b1;
        end
      end
    end
    if (capture) begin
      set_h = 1'b1;
    end
    // a software write lands last so it is never lost to a tick
    if (wr_cl) begin
      low_counter_nxt = req.wdata;
    end
    if (wr_ch) begin
      high_counter_nxt = req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      low_counter_r <= `ART_BYTE_RESET;
      high_counter_r <= `ART_BYTE_RESET;
    end else begin
      low_counter_r <= low_counter_nxt;
      high_counter_r <= high_counter_nxt;
    end
  end

  // reload pair: software writes, or a capture of the running count
  always_comb begin
    reload_low_byte_nxt = reload_low_byte_r;
    reload_high_byte_nxt = reload_high_byte_r;
    if (capture) begin
      reload_low_byte_nxt = low_counter_r;
      reload_high_byte_nxt = high_counter_r;
    end
    // software wins over a capture in the same cycle
    if (wr_rll) begin
      reload_low_byte_nxt = req.wdata;
    end
    if (wr_rlh) begin
      reload_high_byte_nxt = req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reload_low_byte_r <= `ART_BYTE_RESET;
      reload_high_byte_r <= `ART_BYTE_RESET;
    end else begin
      reload_low_byte_r <= reload_low_byte_nxt;
      reload_high_byte_r <= reload_high_byte_nxt;
    end
  end

  // control register
  always_comb begin
    high_overflow_flag_nxt = high_overflow_flag_r;
    low_overflow_flag_nxt = low_overflow_flag_r;
    low_overflow_irq_enable_nxt = low_overflow_irq_enable_r;
    lowfreq_capture_enable_nxt = lowfreq_capture_enable_r;
    split_mode_select_nxt = split_mode_select_r;
    run_control_nxt = run_control_r;
    external_clock_select_nxt = external_clock_select_r;
    if (wr_ctrl) begin
      high_overflow_flag_nxt = req.wdata[`ART_BIT_TFH];
      low_overflow_flag_nxt = req.wdata[`ART_BIT_TFL];
      low_overflow_irq_enable_nxt = req.wdata[`ART_BIT_LEN];
      lowfreq_capture_enable_nxt = req.wdata[`ART_BIT_CEN];
      split_mode_select_nxt = req.wdata[`ART_BIT_SPLIT];
      run_control_nxt = req.wdata[`ART_BIT_RUN];
      external_clock_select_nxt = req.wdata[`ART_BIT_XCLK];
    end
    // hardware set beats a same-cycle software clear
    high_overflow_flag_nxt = high_overflow_flag_nxt | set_h;
    low_overflow_flag_nxt = low_overflow_flag_nxt | set_l;
  end

  // read port and interrupt request, both registered toward the core
  always_comb begin
    // level request held while timer_irq_enable is high and the high flag, or the low flag with its enable, stays set; service code clears it
    irq_req_nxt = timer_irq_enable && (high_overflow_flag_nxt ||
                  (low_overflow_irq_enable_nxt &&
                   low_overflow_flag_nxt));
    sfr_rdata_nxt = sfr_rdata_r;
    if (req.rd) begin
      case (req.addr)
        `ART_ADDR_CTRL: sfr_rdata_nxt = ctrl_image(high_overflow_flag_r,
            low_overflow_flag_r, low_overflow_irq_enable_r,
            lowfreq_capture_enable_r, split_mode_select_r, run_control_r,
            external_clock_select_r);
        // count bytes are read one at a time; no snapshot of the pair
        `ART_ADDR_RLD_LO: sfr_rdata_nxt = reload_low_byte_r;
        `ART_ADDR_RLD_HI: sfr_rdata_nxt = reload_high_byte_r;
        `ART_ADDR_CNT_LO: sfr_rdata_nxt = low_counter_r;
        `ART_ADDR_CNT_HI: sfr_rdata_nxt = high_counter_r;
        default: sfr_rdata_nxt = `ART_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      high_overflow_flag_r <= 1'b0;
      low_overflow_flag_r <= 1'b0;
      low_overflow_irq_enable_r <= 1'b0;
      lowfreq_capture_enable_r <= 1'b0;
      split_mode_select_r <= 1'b0;
      run_control_r <= 1'b0;
      external_clock_select_r <= 1'b0;
    end else begin
      high_overflow_flag_r <= high_overflow_flag_nxt;
      low_overflow_flag_r <= low_overflow_flag_nxt;
      low_overflow_irq_enable_r <= low_overflow_irq_enable_nxt;
      lowfreq_capture_enable_r <= lowfreq_capture_enable_nxt;
      split_mode_select_r <= split_mode_select_nxt;
      run_control_r <= run_control_nxt;
      external_clock_select_r <= external_clock_select_nxt;
    end
  end

  // read data holds between reads, so a late sample still sees it
  always_ff @(posedge clock) begin
    if (reset) begin
      sfr_rdata_r <= `ART_BYTE_ZERO;
      irq_req_r <= 1'b0;
    end else begin
      sfr_rdata_r <= sfr_rdata_nxt;
      irq_req_r <= irq_req_nxt;
    end
  end

endmodule : art_timer

// ---- design/art_cfg.svh ----
// constants for the auto-reload timer: sfr offsets, bit positions, resets
// assumes one sfr space shared with the rest of the core
`ifndef ART_CFG_SVH
`define ART_CFG_SVH

`define ART_ADDR_CTRL 8'h91
`define ART_ADDR_RLD_LO 8'h92
`define ART_ADDR_RLD_HI 8'h93
`define ART_ADDR_CNT_LO 8'h94
`define ART_ADDR_CNT_HI 8'h95

`define ART_BIT_TFH 7
`define ART_BIT_TFL 6
`define ART_BIT_LEN 5
`define ART_BIT_CEN 4
`define ART_BIT_SPLIT 3
`define ART_BIT_RUN 2
`define ART_BIT_XCLK 0

`define ART_CTRL_RESET 8'h00
`define ART_BYTE_RESET 8'h00
`define ART_BYTE_MAX 8'hff
`define ART_BYTE_ZERO 8'h00

`define ART_SYS_DIV 12
`define ART_EXT_DIV 8

`endif

// ---- design/art_pkg.sv ----
// types shared by the timer and its clock-source helper
// assumes art_cfg.svh supplies the numeric constants
package art_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } art_sfr_req_t;

  typedef struct packed {
    logic tick_sys_div;
    logic tick_ext_div;
    logic ext_edge;
  } art_ticks_t;

  typedef enum logic [1:0] {
    ART_SRC_DIV12,
    ART_SRC_EXT8,
    ART_SRC_SYS
  } art_src_t;

endpackage : art_pkg

// ---- design/art_clk_src.sv ----
// clock-source helper: system clock divided by 12, and the external
// oscillator synchronised and divided by 8, both as one-cycle ticks
// assumes ext_osc is asynchronous to clock and slower than clock / 2
`timescale 1ns/1ps
`include "art_cfg.svh"
module art_clk_src import art_pkg::*; #(
  parameter int SYS_DIV = `ART_SYS_DIV,
  parameter int EXT_DIV = `ART_EXT_DIV
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic ext_osc,
  output art_ticks_t ticks
);

  localparam int SW = $clog2(SYS_DIV);
  localparam int EW = $clog2(EXT_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

  logic sync1_r, sync2_r, prev_r;
  logic [SW-1:0] sys_cnt_r, sys_cnt_nxt;
  logic [EW-1:0] ext_cnt_r, ext_cnt_nxt;
  logic edge_w;

  // first stage feeds only the second
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= ext_osc;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign edge_w = sync2_r & ~prev_r;

  always_comb begin
    sys_cnt_nxt = (sys_cnt_r == SYS_LAST) ? '0 : sys_cnt_r + 1'b1;
    ext_cnt_nxt = ext_cnt_r;
    if (edge_w) begin
      ext_cnt_nxt = (ext_cnt_r == EXT_LAST) ? '0 : ext_cnt_r + 1'b1;
    end
    ticks.tick_sys_div = (sys_cnt_r == SYS_LAST);
    ticks.tick_ext_div = edge_w && (ext_cnt_r == EXT_LAST);
    ticks.ext_edge = edge_w;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sys_cnt_r <= '0;
      ext_cnt_r <= '0;
    end else begin
      sys_cnt_r <= sys_cnt_nxt;
      ext_cnt_r <= ext_cnt_nxt;
    end
  end

endmodule : art_clk_src

// ---- dv/art_timer_checker.sv ----
// port-level checks for the auto-reload timer
// assumes it is bound to art_timer and sees only that module's ports
`timescale 1ns/1ps
module art_timer_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic timer_irq_enable,
  input wire logic high_byte_clock_select,
  input wire logic low_byte_clock_select,
  input wire logic ext_osc,
  input wire logic [7:0] sfr_rdata_r,
  input wire logic irq_req_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic ctrl_rd;
  logic ctrl_wr;
  logic [7:0] wd_r;
  assign ctrl_rd = sfr_rd && sfr_addr == 8'h91 && !sfr_wr;
  assign ctrl_wr = sfr_wr && sfr_addr == 8'h91;
  // only software touches bits 5..2 and 0, so the last write predicts them
  always_ff @(posedge clock) begin
    if (reset) begin
      wd_r <= 8'h00;
    end else if (ctrl_wr) begin
      wd_r <= sfr_wdata;
    end
  end
  a_bit1_reads_zero: assert property (ctrl_rd |=> !sfr_rdata_r[1])
    else $error("control bit 1 read as one");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata_r))
    else $error("read data moved without a read");
  a_ctrl_bits_kept: assert property (ctrl_rd |=>
    sfr_rdata_r[5:2] == wd_r[5:2] && sfr_rdata_r[0] == wd_r[0])
    else $error("control bits differ from last write");
  a_irq_needs_ie: assert property (!timer_irq_enable |=> !irq_req_r)
    else $error("request without interrupt enable");
  a_irq_high_flag: assert property (ctrl_rd && timer_irq_enable |=>
    !sfr_rdata_r[7] || irq_req_r) else $error("high flag gave no request");
  a_irq_low_flag: assert property (ctrl_rd && timer_irq_enable |=>
    !(sfr_rdata_r[6] && sfr_rdata_r[5]) || irq_req_r)
    else $error("enabled low flag gave no request");
  a_irq_needs_flag: assert property (ctrl_rd |=>
    $past(irq_req_r) == ($past(timer_irq_enable, 2) &&
    (sfr_rdata_r[7] || (sfr_rdata_r[6] && sfr_rdata_r[5]))))
    else $error("request differs from flags read");
  a_irq_stays_set: assert property (irq_req_r && timer_irq_enable &&
    !ctrl_wr && !$past(ctrl_wr) |=> irq_req_r)
    else $error("request dropped without a clear");
  a_reset_clears: assert property (@(posedge clock) disable iff (1'b0)
    reset |=> sfr_rdata_r == 8'h00 && !irq_req_r)
    else $error("outputs not cleared by reset");
  cover property (ctrl_rd ##1 sfr_rdata_r[7]);
  cover property ($rose(irq_req_r));
  cover property (sfr_rd && sfr_addr == 8'h96);
  cover property (ctrl_wr && sfr_wdata[4]);
endmodule : art_timer_checker

bind art_timer art_timer_checker u_chk (.clock(clock), .reset(reset),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .timer_irq_enable(timer_irq_enable),
  .high_byte_clock_select(high_byte_clock_select),
  .low_byte_clock_select(low_byte_clock_select), .ext_osc(ext_osc),
  .sfr_rdata_r(sfr_rdata_r), .irq_req_r(irq_req_r));

// ---- dv/art_timer_tb_top.sv ----
// self-checking bench for the auto-reload timer through its sfr port
// assumes the checker is bound to the design from its own file
`timescale 1ns/1ps
module art_timer_tb_top;
  logic clock, reset, sfr_wr, sfr_rd, timer_irq_enable, ext_osc, ext_en;
  logic high_byte_clock_select, low_byte_clock_select, irq_req_r;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r, v;
  logic [2:0] ph;
  int n_fail, samples_checked, cycles;
  art_timer u_dut (.clock(clock), .reset(reset), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .timer_irq_enable(timer_irq_enable),
    .high_byte_clock_select(high_byte_clock_select),
    .low_byte_clock_select(low_byte_clock_select), .ext_osc(ext_osc),
    .sfr_rdata_r(sfr_rdata_r), .irq_req_r(irq_req_r));
  always #10 clock = ~clock;
  // oscillator period of ten system cycles, unrelated to any bus access
  always @(posedge clock) begin
    ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
    if (ext_en && ph == 3'h4) ext_osc <= ~ext_osc;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1 v = sfr_rdata_r;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
    input logic [7:0] m);
    rd(a);
    chk($sformatf("reg %h", a), e & m, v & m);
  endtask : rchk
  task automatic irq_is(input int n, input logic e);
    #1;
    for (int i = 0; i < n && irq_req_r !== e; i++) begin
      @(posedge clock);
      #1;
    end
    chk("irq", {7'h0, e}, {7'h0, irq_req_r});
  endtask : irq_is
  task automatic span(input string n, input logic [7:0] lo, hi);
    chk(n, 8'h01, {7'h0, v >= lo && v <= hi});
  endtask : span
  initial begin
    {clock, sfr_wr, sfr_rd, timer_irq_enable, ext_osc, ext_en} = '0;
    {sfr_addr, sfr_wdata, ph, cycles, n_fail, samples_checked} = '0;
    high_byte_clock_select = 1'b0;
    low_byte_clock_select = 1'b1;
    reset = 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    for (int a = 'h91; a <= 'h96; a++) rchk(8'(a), 8'h00, 8'hff);
    wr(8'h95, 8'h55);
    wr(8'h91, 8'h0a);
    rchk(8'h91, 8'h08, 8'hbf);
    repeat (20) @(posedge clock);
    rchk(8'h95, 8'h55, 8'hff);
    rd(8'h94);
    span("low runs", 8'h01, 8'hff);
    wr(8'h92, 8'hfe);
    timer_irq_enable <= 1'b1;
    wr(8'h91, 8'h28);
    irq_is(300, 1'b1);
    rchk(8'h91, 8'h68, 8'hff);
    rchk(8'h94, 8'hfe, 8'hfe);
    wr(8'h93, 8'hf0);
    high_byte_clock_select <= 1'b1;
    wr(8'h91, 8'h0c);
    irq_is(400, 1'b1);
    rchk(8'h95, 8'hf0, 8'hf0);
    wr(8'h91, 8'h88);
    repeat (20) @(posedge clock);
    irq_is(1, 1'b1);
    wr(8'h91, 8'h48);
    irq_is(3, 1'b0);
    wr(8'h91, 8'h00);
    wr(8'h92, 8'h34);
    wr(8'h93, 8'h12);
    wr(8'h94, 8'hf0);
    wr(8'h95, 8'hff);
    wr(8'h91, 8'h04);
    irq_is(100, 1'b1);
    rchk(8'h95, 8'h12, 8'hff);
    rchk(8'h91, 8'hc4, 8'hcf);
    wr(8'h91, 8'h00);
    wr(8'h94, 8'h10);
    repeat (30) @(posedge clock);
    rchk(8'h94, 8'h10, 8'hff);
    timer_irq_enable <= 1'b0;
    low_byte_clock_select <= 1'b0;
    wr(8'h91, 8'h04);
    repeat (240) @(posedge clock);
    wr(8'h91, 8'h00);
    rd(8'h94);
    span("div12", 8'h23, 8'h26);
    wr(8'h94, 8'h00);
    ext_en <= 1'b1;
    wr(8'h91, 8'h05);
    repeat (800) @(posedge clock);
    wr(8'h91, 8'h01);
    rd(8'h94);
    span("ext8", 8'h09, 8'h0b);
    wr(8'h91, 8'h00);
    wr(8'h94, 8'hf8);
    low_byte_clock_select <= 1'b1;
    timer_irq_enable <= 1'b1;
    wr(8'h91, 8'h24);
    irq_is(40, 1'b1);
    rchk(8'h91, 8'h64, 8'hff);
    wr(8'h91, 8'h00);
    wr(8'h94, 8'h5a);
    wr(8'h95, 8'ha5);
    wr(8'h91, 8'h10);
    irq_is(40, 1'b1);
    rchk(8'h92, 8'h5a, 8'hff);
    rchk(8'h93, 8'ha5, 8'hff);
    rchk(8'h91, 8'h90, 8'hff);
    wrap_up();
  end
endmodule : art_timer_tb_top
